// file: cpc_pkg.sv
// Constants, register map and decode helpers for the channel pin control
// block. Shared by the control top, its checker, the board model and the bench.
package cpc_pkg;

    localparam int          CPC_ADDR_W      = 4;
    localparam int          CPC_DATA_W      = 32;

    // Register byte addresses
    localparam logic [3:0]  CPC_OFS_CTRL    = 4'h0;
    localparam logic [3:0]  CPC_OFS_STATUS  = 4'h4;
    localparam logic [3:0]  CPC_OFS_RATE    = 4'h8;

    // Control register fields
    localparam int          CTRL_CODEC_BIT  = 0;
    localparam int          CTRL_LOS_EN_BIT = 1;
    localparam int          CTRL_PWRDN_BIT  = 2;
    localparam int          CTRL_DPRST_BIT  = 3;
    localparam int          CTRL_LSEL_LSB   = 4;
    localparam logic [5:0]  CTRL_RESET      = 6'h00;

    // Rate register fields
    localparam int          RATE_SW_LSB     = 0;
    localparam logic [1:0]  RATE_RESET      = 2'h0;

    // Status register fields
    localparam int          ST_LOS_BIT      = 0;
    localparam int          ST_LOS_OE_BIT   = 1;
    localparam int          ST_CODEC_BIT    = 2;
    localparam int          ST_PDA_BIT      = 3;
    localparam int          ST_PDB_BIT      = 4;
    localparam int          ST_RATE_LSB     = 8;
    localparam int          ST_SRC_LSB      = 10;
    localparam int          ST_MODE_LSB     = 12;
    localparam int          ST_STRAP_B_LSB  = 20;
    localparam int          ST_STRAP_A_LSB  = 24;

    // Rate select strap codes
    localparam logic [2:0]  RSEL_FULL       = 3'h0;
    localparam logic [2:0]  RSEL_HALF       = 3'h1;
    localparam logic [2:0]  RSEL_QUARTER    = 3'h2;
    localparam logic [2:0]  RSEL_EIGHTH     = 3'h3;
    localparam logic [2:0]  RSEL_SOFT       = 3'h4;
    localparam logic [2:0]  RSEL_AUTO       = 3'h5;
    localparam logic [2:0]  RSEL_AUTO_PRI   = 3'h6;
    localparam logic [2:0]  RSEL_SLAVE      = 3'h7;

    // Serializer settings source
    localparam logic [1:0]  SRC_STRAP       = 2'h0;
    localparam logic [1:0]  SRC_SOFT        = 2'h1;
    localparam logic [1:0]  SRC_DET_OWN     = 2'h2;
    localparam logic [1:0]  SRC_DET_PEER    = 2'h3;

    // Signal-loss pin source select
    localparam logic [1:0]  LSEL_LOSS       = 2'h0;
    localparam logic [1:0]  LSEL_STAT_0     = 2'h1;
    localparam logic [1:0]  LSEL_STAT_1     = 2'h2;
    localparam logic [1:0]  LSEL_STAT_2     = 2'h3;

    typedef enum logic [4:0] {
        CPC_MODE_FIXED    = 5'h01,
        CPC_MODE_SOFT     = 5'h02,
        CPC_MODE_AUTO     = 5'h04,
        CPC_MODE_AUTO_PRI = 5'h08,
        CPC_MODE_SLAVE    = 5'h10
    } cpc_mode_type;

    function automatic logic cpc_is_auto(input logic [2:0] code);
        cpc_is_auto = (code == RSEL_AUTO) || (code == RSEL_AUTO_PRI);
    endfunction

    function automatic cpc_mode_type cpc_decode(input logic [2:0] code);
        case (code)
            RSEL_SOFT:     cpc_decode = CPC_MODE_SOFT;
            RSEL_AUTO:     cpc_decode = CPC_MODE_AUTO;
            RSEL_AUTO_PRI: cpc_decode = CPC_MODE_AUTO_PRI;
            RSEL_SLAVE:    cpc_decode = CPC_MODE_SLAVE;
            default:       cpc_decode = CPC_MODE_FIXED;
        endcase
    endfunction

endpackage

// file: cpc_sync.sv
// Two-flop synchroniser for static strap and pin levels.
// Assumes inputs are slow levels; multi-bit buses may skew one cycle.
`timescale 1ns/100ps
module cpc_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // cpc_sync

// file: cpc_top.sv
// Pin control and status for a transceiver channel pair: codec enable,
// signal-loss pin, power-down, channel B serial output and rate decode.
// Assumes an Avalon-MM master on mclk_in and analog pins outside.
//
// Operation
// - Codec enable pin high turns on channel A encoder and decoder.
// - Codec pin ORed with software bit; software works only with pin low.
// - Loss pin reads 0 on signal, 1 on loss when detect enabled.
// - Software may route other live status onto the loss pin.
// - During device reset the loss pin is driven low.
// - Channel A power-down pin low floats the loss pin.
// - Register power-down bit set floats the loss pin.
// - Power-down pin low holds channel A down; release resumes it.
// - During device reset channel B serial pair shows differential zero.
// - Channel B pair floats on its power-down pin or register bit.
// - Codes 000 to 011 fix full, half, quarter, eighth rate.
// - Code 100 hands the rate choice to software registers.
// - Code 101 enables auto detector; clock output follows select.
// - Code 110 enables detector, ignores select, top clock priority.
// - Code 111 slaves B to A's detector, else own registers.
// - The rate code governs transmit and receive of channel B.
`timescale 1ns/100ps
module cpc_top
    import cpc_pkg::*;
(
    input  wire logic                  mclk_in,
    input  wire logic                  rst_b_in,
    // Avalon-MM slave
    input  wire logic [CPC_ADDR_W-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [CPC_DATA_W-1:0] avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [CPC_DATA_W-1:0] avs_readdata_out,
    output logic                       avs_waitrequest_out,
    // Straps and pins
    input  wire logic                  codec_enable_chan_a_in,
    input  wire logic                  chan_a_powerdown_low_in,
    input  wire logic                  chan_b_powerdown_low_in,
    input  wire logic [2:0]            rate_sel_a_in,
    input  wire logic [2:0]            rate_sel_b_in,
    input  wire logic                  loss_detect_a_in,
    input  wire logic [2:0]            live_status_a_in,
    // Detector results and channel B transmit bit, same clock
    input  wire logic [1:0]            det_rate_a_in,
    input  wire logic [1:0]            det_rate_b_in,
    input  wire logic                  tx_bit_b_in,
    // Channel A
    output logic                       codec_en_a_out,
    output logic                       chan_a_down_out,
    output logic                       datapath_reset_a_out,
    output logic                       signal_loss_flag_a_out,
    output logic                       signal_loss_flag_a_oe_out,
    // Channel B
    output logic                       serial_out_b_pos_out,
    output logic                       serial_out_b_neg_out,
    output logic                       serial_out_b_oe_out,
    output logic                       chan_b_down_out,
    output logic [1:0]                 rate_b_out,
    output logic [1:0]                 rate_src_b_out,
    output logic                       auto_rate_detect_b_out,
    output logic                       clk_out_follow_sel_b_out,
    output logic                       clk_out_priority_b_out
);

    logic                  codec_s;
    logic                  pda_low_s;
    logic                  pdb_low_s;
    logic [2:0]            rsel_a_s;
    logic [2:0]            rsel_b_s;
    logic                  loss_s;
    logic [2:0]            live_s;

    // Strap sync
    // two-flop straps
    cpc_sync #(.WIDTH(13), .INIT(13'h0C00)) u_strap_sync (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .async_in ({codec_enable_chan_a_in, chan_a_powerdown_low_in,
                    chan_b_powerdown_low_in, rate_sel_a_in,
                    rate_sel_b_in, loss_detect_a_in, live_status_a_in}),
        .sync_out ({codec_s, pda_low_s, pdb_low_s, rsel_a_s, rsel_b_s,
                    loss_s, live_s})
    );

    // Bus state
    logic                  wait_ff;
    logic                  nxt_wait;
    logic [CPC_DATA_W-1:0] rdata_ff;
    logic [CPC_DATA_W-1:0] nxt_rdata;
    logic [5:0]            ctrl_ff;
    logic [5:0]            nxt_ctrl;
    logic [1:0]            rate_sw_ff;
    logic [1:0]            nxt_rate_sw;
    logic                  dprst_ff;
    logic                  nxt_dprst;
    logic [CPC_DATA_W-1:0] status_w;
    logic                  wr_take;
    logic                  rd_take;

    // Pin state
    logic                  los_ff;
    logic                  nxt_los;
    logic                  los_oe_ff;
    logic                  nxt_los_oe;
    logic                  codec_ff;
    logic                  nxt_codec;
    logic                  pda_ff;
    logic                  nxt_pda;
    logic                  pdb_ff;
    logic                  nxt_pdb;
    logic                  txp_ff;
    logic                  nxt_txp;
    logic                  txn_ff;
    logic                  nxt_txn;
    logic                  txoe_ff;
    logic                  nxt_txoe;
    logic                  los_raw;

    // Rate state
    cpc_mode_type          mode_ff;
    cpc_mode_type          nxt_mode;
    logic [1:0]            rate_ff;
    logic [1:0]            nxt_rate;
    logic [1:0]            src_ff;
    logic [1:0]            nxt_src;
    logic                  ard_ff;
    logic                  nxt_ard;
    logic                  follow_ff;
    logic                  nxt_follow;
    logic                  prio_ff;
    logic                  nxt_prio;

    // One wait cycle per access keeps read data registered
    assign wr_take = avs_write_in && !wait_ff;
    assign rd_take = avs_read_in && wait_ff;

    always_comb begin
        status_w = '0;
        status_w[ST_LOS_BIT]     = los_ff;
        status_w[ST_LOS_OE_BIT]  = los_oe_ff;
        status_w[ST_CODEC_BIT]   = codec_ff;
        status_w[ST_PDA_BIT]     = pda_ff;
        status_w[ST_PDB_BIT]     = pdb_ff;
        status_w[ST_RATE_LSB+:2] = rate_ff;
        status_w[ST_SRC_LSB+:2]  = src_ff;
        status_w[ST_MODE_LSB+:5] = mode_ff;
        status_w[ST_STRAP_B_LSB+:3] = rsel_b_s;
        status_w[ST_STRAP_A_LSB+:3] = rsel_a_s;
    end

    always_comb begin
        nxt_wait    = !((avs_read_in || avs_write_in) && wait_ff);
        nxt_rdata   = rdata_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_rate_sw = rate_sw_ff;
        nxt_dprst   = 1'b0;
        if (rd_take) begin
            case (avs_address_in)
                CPC_OFS_CTRL:   nxt_rdata = {26'h0, ctrl_ff};
                CPC_OFS_STATUS: nxt_rdata = status_w;
                CPC_OFS_RATE:   nxt_rdata = {30'h0, rate_sw_ff};
                default:        nxt_rdata = '0;
            endcase
        end
        if (wr_take && avs_byteenable_in[0]) begin
            case (avs_address_in)
                CPC_OFS_CTRL: begin
                    nxt_ctrl = avs_writedata_in[5:0];
                    nxt_dprst = avs_writedata_in[CTRL_DPRST_BIT];
                    nxt_ctrl[CTRL_DPRST_BIT] = 1'b0;
                end
                CPC_OFS_RATE:
                    nxt_rate_sw = avs_writedata_in[RATE_SW_LSB+:2];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_ff    <= 1'b1;
            rdata_ff   <= '0;
            ctrl_ff    <= CTRL_RESET;
            rate_sw_ff <= RATE_RESET;
            dprst_ff   <= 1'b0;
        end else begin
            wait_ff    <= nxt_wait;
            rdata_ff   <= nxt_rdata;
            ctrl_ff    <= nxt_ctrl;
            rate_sw_ff <= nxt_rate_sw;
            dprst_ff   <= nxt_dprst;
        end
    end

    // Loss pin source
    always_comb begin
        case (ctrl_ff[CTRL_LSEL_LSB+:2])
            LSEL_LOSS:   los_raw = loss_s && ctrl_ff[CTRL_LOS_EN_BIT];
            LSEL_STAT_0: los_raw = live_s[0];
            LSEL_STAT_1: los_raw = live_s[1];
            LSEL_STAT_2: los_raw = live_s[2];
            default:     los_raw = 1'b0;
        endcase
    end

    always_comb begin
        nxt_codec  = codec_s || ctrl_ff[CTRL_CODEC_BIT];
        nxt_pda    = !pda_low_s || ctrl_ff[CTRL_PWRDN_BIT];
        nxt_pdb    = !pdb_low_s || ctrl_ff[CTRL_PWRDN_BIT];
        nxt_los    = los_raw;
        nxt_los_oe = pda_low_s && !ctrl_ff[CTRL_PWRDN_BIT];
        nxt_txoe   = pdb_low_s && !ctrl_ff[CTRL_PWRDN_BIT];
        nxt_txp    = tx_bit_b_in;
        nxt_txn    = !tx_bit_b_in;
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            codec_ff  <= 1'b0;
            pda_ff    <= 1'b0;
            pdb_ff    <= 1'b0;
            los_ff    <= 1'b0;
            los_oe_ff <= 1'b1;
            txp_ff    <= 1'b0;
            txn_ff    <= 1'b1;
            txoe_ff   <= 1'b1;
        end else begin
            codec_ff  <= nxt_codec;
            pda_ff    <= nxt_pda;
            pdb_ff    <= nxt_pdb;
            los_ff    <= nxt_los;
            los_oe_ff <= nxt_los_oe;
            txp_ff    <= nxt_txp;
            txn_ff    <= nxt_txn;
            txoe_ff   <= nxt_txoe;
        end
    end

    // Rate decode; one setting feeds both directions of channel B
    always_comb begin
        nxt_mode   = cpc_decode(rsel_b_s);
        nxt_rate   = rsel_b_s[1:0];
        nxt_src    = SRC_STRAP;
        nxt_ard    = 1'b0;
        nxt_follow = 1'b1;
        nxt_prio   = 1'b0;
        case (nxt_mode)
            CPC_MODE_FIXED: nxt_rate = rsel_b_s[1:0];
            CPC_MODE_SOFT: begin
                nxt_rate = rate_sw_ff;
                nxt_src  = SRC_SOFT;
            end
            CPC_MODE_AUTO: begin
                nxt_rate = det_rate_b_in;
                nxt_src  = SRC_DET_OWN;
                nxt_ard  = 1'b1;
            end
            CPC_MODE_AUTO_PRI: begin
                nxt_rate   = det_rate_b_in;
                nxt_src    = SRC_DET_OWN;
                nxt_ard    = 1'b1;
                nxt_follow = 1'b0;
                nxt_prio   = 1'b1;
            end
            CPC_MODE_SLAVE: begin
                if (cpc_is_auto(rsel_a_s)) begin
                    nxt_rate   = det_rate_a_in;
                    nxt_src    = SRC_DET_PEER;
                    nxt_follow = 1'b0;
                end else begin
                    nxt_rate = rate_sw_ff;
                    nxt_src  = SRC_SOFT;
                end
            end
            default: nxt_rate = rsel_b_s[1:0];
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_ff   <= CPC_MODE_FIXED;
            rate_ff   <= 2'h0;
            src_ff    <= SRC_STRAP;
            ard_ff    <= 1'b0;
            follow_ff <= 1'b1;
            prio_ff   <= 1'b0;
        end else begin
            mode_ff   <= nxt_mode;
            rate_ff   <= nxt_rate;
            src_ff    <= nxt_src;
            ard_ff    <= nxt_ard;
            follow_ff <= nxt_follow;
            prio_ff   <= nxt_prio;
        end
    end

    assign avs_readdata_out          = rdata_ff;
    assign avs_waitrequest_out       = wait_ff;
    assign codec_en_a_out            = codec_ff;
    assign chan_a_down_out           = pda_ff;
    assign datapath_reset_a_out      = dprst_ff;
    assign signal_loss_flag_a_out    = los_ff;
    assign signal_loss_flag_a_oe_out = los_oe_ff;
    assign serial_out_b_pos_out      = txp_ff;
    assign serial_out_b_neg_out      = txn_ff;
    assign serial_out_b_oe_out       = txoe_ff;
    assign chan_b_down_out           = pdb_ff;
    assign rate_b_out                = rate_ff;
    assign rate_src_b_out            = src_ff;
    assign auto_rate_detect_b_out    = ard_ff;
    assign clk_out_follow_sel_b_out  = follow_ff;
    assign clk_out_priority_b_out    = prio_ff;

endmodule // cpc_top

// file: cpc_props.sv
// Port-level checker for cpc_top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module cpc_props
    import cpc_pkg::*;
(
    input wire logic       mclk_in,
    input wire logic       rst_b_in,
    input wire logic       avs_read_in,
    input wire logic       avs_write_in,
    input wire logic       avs_waitrequest_out,
    input wire logic       codec_enable_chan_a_in,
    input wire logic       chan_a_powerdown_low_in,
    input wire logic       chan_b_powerdown_low_in,
    input wire logic [2:0] rate_sel_a_in,
    input wire logic [2:0] rate_sel_b_in,
    input wire logic       codec_en_a_out,
    input wire logic       chan_a_down_out,
    input wire logic       datapath_reset_a_out,
    input wire logic       signal_loss_flag_a_out,
    input wire logic       signal_loss_flag_a_oe_out,
    input wire logic       serial_out_b_pos_out,
    input wire logic       serial_out_b_neg_out,
    input wire logic       serial_out_b_oe_out,
    input wire logic       chan_b_down_out,
    input wire logic [1:0] rate_b_out,
    input wire logic [1:0] rate_src_b_out,
    input wire logic       auto_rate_detect_b_out,
    input wire logic       clk_out_follow_sel_b_out,
    input wire logic       clk_out_priority_b_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    // Six edges cover the two sync flops plus the output flop
    sequence fixed_held;
        ($stable(rate_sel_b_in) && rate_sel_b_in < RSEL_SOFT) [*6];
    endsequence
    sequence code_held(logic [2:0] c);
        (rate_sel_b_in == c) [*6];
    endsequence
    sequence peer_held;
        (rate_sel_b_in == RSEL_SLAVE && (rate_sel_a_in == RSEL_AUTO
            || rate_sel_a_in == RSEL_AUTO_PRI)) [*6];
    endsequence

    fixed_rate_a: assert property (fixed_held |->
        rate_b_out == rate_sel_b_in[1:0] && rate_src_b_out == SRC_STRAP)
        else $error("fixed rate code not applied");
    soft_rate_a: assert property (code_held(RSEL_SOFT) |->
        rate_src_b_out == SRC_SOFT) else $error("soft rate source wrong");
    auto_follow_a: assert property (code_held(RSEL_AUTO) |->
        auto_rate_detect_b_out && clk_out_follow_sel_b_out
        && !clk_out_priority_b_out && rate_src_b_out == SRC_DET_OWN)
        else $error("auto mode outputs wrong");
    auto_prio_a: assert property (code_held(RSEL_AUTO_PRI) |->
        auto_rate_detect_b_out && !clk_out_follow_sel_b_out
        && clk_out_priority_b_out && rate_src_b_out == SRC_DET_OWN)
        else $error("priority auto mode outputs wrong");
    slave_peer_a: assert property (peer_held |->
        rate_src_b_out == SRC_DET_PEER) else $error("slave source wrong");
    pin_down_b_a: assert property ((!chan_b_powerdown_low_in) [*6] |->
        !serial_out_b_oe_out && chan_b_down_out)
        else $error("channel B not floated on pin power-down");
    pin_down_a_a: assert property ((!chan_a_powerdown_low_in) [*6] |->
        !signal_loss_flag_a_oe_out && chan_a_down_out)
        else $error("channel A not down on pin power-down");
    codec_pin_a: assert property (codec_enable_chan_a_in [*6] |->
        codec_en_a_out) else $error("codec not enabled by pin");
    reset_drive_a: assert property (disable iff (1'b0) !rst_b_in |->
        !signal_loss_flag_a_out && signal_loss_flag_a_oe_out
        && !serial_out_b_pos_out && serial_out_b_neg_out
        && serial_out_b_oe_out) else $error("reset pin levels wrong");
    pair_diff_a: assert property (serial_out_b_oe_out |->
        serial_out_b_neg_out != serial_out_b_pos_out)
        else $error("serial pair not differential");
    wait_pulse_a: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out ##1
        avs_waitrequest_out) else $error("waitrequest pulse wrong");
    reset_pulse_a: assert property (datapath_reset_a_out |=>
        !datapath_reset_a_out) else $error("datapath reset too long");
endmodule // cpc_props

bind cpc_top cpc_props u_props (.mclk_in, .rst_b_in, .avs_read_in,
    .avs_write_in, .avs_waitrequest_out, .codec_enable_chan_a_in,
    .chan_a_powerdown_low_in, .chan_b_powerdown_low_in, .rate_sel_a_in,
    .rate_sel_b_in, .codec_en_a_out, .chan_a_down_out,
    .datapath_reset_a_out, .signal_loss_flag_a_out,
    .signal_loss_flag_a_oe_out, .serial_out_b_pos_out,
    .serial_out_b_neg_out, .serial_out_b_oe_out, .chan_b_down_out,
    .rate_b_out, .rate_src_b_out, .auto_rate_detect_b_out,
    .clk_out_follow_sel_b_out, .clk_out_priority_b_out);

// file: cpc_board.sv
// Board strap model: turns requested rate codes into strap levels.
// Assumes the bench changes requests just after a clock edge.
`timescale 1ns/100ps
module cpc_board
    import cpc_pkg::*;
(
    input  wire logic [2:0] want_a_in,
    input  wire logic [2:0] want_b_in,
    output logic      [2:0] rate_sel_a_out,
    output logic      [2:0] rate_sel_b_out
);
    always_comb begin
        rate_sel_a_out = want_a_in;
        rate_sel_b_out = want_b_in;
        // Such a strap is illegal; A falls back to software rate
        if (want_a_in == want_b_in && want_b_in[2:1] == 2'h3) begin
            rate_sel_a_out = RSEL_SOFT;
        end
    end
endmodule // cpc_board

// file: tb_top.sv
// Self-checking bench for cpc_top: register bus, straps and pins.
// Assumes cpc_props is bound in its own file.
`timescale 1ns/100ps
module tb_top import cpc_pkg::*;;
    logic        mclk_in = 1'b0;
    logic        rst_b_in = 1'b1;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'hF;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        codec_enable_chan_a_in = 1'b0;
    logic        chan_a_powerdown_low_in = 1'b1;
    logic        chan_b_powerdown_low_in = 1'b1;
    logic [2:0]  want_a = 3'h0;
    logic [2:0]  want_b = 3'h0;
    logic [2:0]  rate_sel_a_in, rate_sel_b_in;
    logic        loss_detect_a_in = 1'b0;
    logic [2:0]  live_status_a_in = 3'h0;
    logic [1:0]  det_rate_a_in = 2'h3;
    logic [1:0]  det_rate_b_in = 2'h1;
    logic        tx_bit_b_in = 1'b0;
    logic        codec_en_a_out, chan_a_down_out, datapath_reset_a_out;
    logic        signal_loss_flag_a_out, signal_loss_flag_a_oe_out;
    logic        serial_out_b_pos_out, serial_out_b_neg_out;
    logic        serial_out_b_oe_out, chan_b_down_out;
    logic [1:0]  rate_b_out, rate_src_b_out;
    logic        auto_rate_detect_b_out, clk_out_follow_sel_b_out;
    logic        clk_out_priority_b_out;
    logic [31:0] q;
    int          fails = 0;
    int          total_checks = 0;
    int          pulses = 0;
    // Mode bits: detect, follow, priority, source, rate
    logic [6:0]  exp_b [8] = '{7'h20, 7'h21, 7'h22, 7'h23,
                               7'h26, 7'h69, 7'h59, 7'h26};
    wire logic [6:0] b_mode = {auto_rate_detect_b_out,
        clk_out_follow_sel_b_out, clk_out_priority_b_out,
        rate_src_b_out, rate_b_out};
    wire logic [4:0] pin_state = {signal_loss_flag_a_out,
        signal_loss_flag_a_oe_out, serial_out_b_pos_out,
        serial_out_b_neg_out, serial_out_b_oe_out};

    cpc_board board (.want_a_in(want_a), .want_b_in(want_b),
        .rate_sel_a_out(rate_sel_a_in), .rate_sel_b_out(rate_sel_b_in));
    cpc_top uut (.mclk_in, .rst_b_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_readdata_out, .avs_waitrequest_out, .codec_enable_chan_a_in,
        .chan_a_powerdown_low_in, .chan_b_powerdown_low_in, .rate_sel_a_in,
        .rate_sel_b_in, .loss_detect_a_in, .live_status_a_in,
        .det_rate_a_in, .det_rate_b_in, .tx_bit_b_in, .codec_en_a_out,
        .chan_a_down_out, .datapath_reset_a_out, .signal_loss_flag_a_out,
        .signal_loss_flag_a_oe_out, .serial_out_b_pos_out,
        .serial_out_b_neg_out, .serial_out_b_oe_out, .chan_b_down_out,
        .rate_b_out, .rate_src_b_out, .auto_rate_detect_b_out,
        .clk_out_follow_sel_b_out, .clk_out_priority_b_out);

    always #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (datapath_reset_a_out === 1'b1) pulses++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr_en, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr_en;
        avs_write_in <= wr_en;
        do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // Three edges through the two sync flops and output flop; seven fill the checker windows
    task automatic settle;
        repeat (7) @(posedge mclk_in);
    endtask
    task automatic done(input string name);
        $display("Test %s finished, mismatches so far %0d", name, fails);
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge mclk_in);
        fails++;
        stop_test;
    end

    initial begin
        rst_b_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk(pin_state, 5'h0B);
        repeat (2) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rd(CPC_OFS_CTRL, 32'h0);
        rd(CPC_OFS_RATE, 32'h0);
        rd(4'hC, 32'h0);
        done("reset");
        wr(CPC_OFS_RATE, 32'h2);
        for (int c = 0; c < 8; c++) begin
            want_b <= 3'(c);
            settle;
            chk(b_mode, exp_b[c]);
        end
        want_a <= RSEL_AUTO;
        settle;
        chk(b_mode, 7'h0F);
        bus(1'b0, CPC_OFS_STATUS, 32'h0);
        chk(q[16:12], 5'h10);
        chk(q[22:20], 3'h7);
        want_a <= 3'h0;
        want_b <= 3'h0;
        tx_bit_b_in <= 1'b1;
        settle;
        chk(pin_state, 5'h0D);
        done("rate");
        wr(CPC_OFS_CTRL, 32'h1);
        settle;
        chk(codec_en_a_out, 1'b1);
        wr(CPC_OFS_CTRL, 32'h0);
        codec_enable_chan_a_in <= 1'b1;
        settle;
        chk(codec_en_a_out, 1'b1);
        codec_enable_chan_a_in <= 1'b0;
        loss_detect_a_in <= 1'b1;
        settle;
        chk(codec_en_a_out, 1'b0);
        chk(signal_loss_flag_a_out, 1'b0);
        wr(CPC_OFS_CTRL, 32'h2);
        settle;
        chk(signal_loss_flag_a_out, 1'b1);
        loss_detect_a_in <= 1'b0;
        settle;
        chk(signal_loss_flag_a_out, 1'b0);
        for (int s = 1; s < 4; s++) begin
            live_status_a_in <= 3'(1 << (s - 1));
            wr(CPC_OFS_CTRL, 32'(s << 4));
            settle;
            chk(signal_loss_flag_a_out, 1'b1);
        end
        done("codec and loss");
        wr(CPC_OFS_CTRL, 32'h0);
        chan_a_powerdown_low_in <= 1'b0;
        settle;
        chk({signal_loss_flag_a_oe_out, chan_a_down_out}, 2'h1);
        chan_a_powerdown_low_in <= 1'b1;
        settle;
        chk({signal_loss_flag_a_oe_out, chan_a_down_out}, 2'h2);
        wr(CPC_OFS_CTRL, 32'h8);
        settle;
        chk(32'(pulses), 32'h1);
        rd(CPC_OFS_CTRL, 32'h0);
        chan_b_powerdown_low_in <= 1'b0;
        settle;
        chk({serial_out_b_oe_out, chan_b_down_out}, 2'h1);
        chan_b_powerdown_low_in <= 1'b1;
        wr(CPC_OFS_CTRL, 32'h4);
        settle;
        chk({signal_loss_flag_a_oe_out, serial_out_b_oe_out}, 2'h0);
        bus(1'b0, CPC_OFS_STATUS, 32'h0);
        chk(q[4:3], 2'h3);
        wr(CPC_OFS_STATUS, 32'hF);
        wr(4'hC, 32'hF);
        avs_byteenable_in <= 4'hE;
        wr(CPC_OFS_CTRL, 32'h0);
        avs_byteenable_in <= 4'hF;
        rd(CPC_OFS_CTRL, 32'h4);
        rd(4'hC, 32'h0);
        done("power-down");
        rst_b_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk(pin_state, 5'h0B);
        rst_b_in <= 1'b1;
        rd(CPC_OFS_CTRL, 32'h0);
        done("mid-run reset");
        stop_test;
    end
endmodule // tb_top
